/* File: hw/multiply_divide_coprocessor.sv */
// multiply/divide co-processor behind seven byte-wide special function registers
// assumes one write or read strobe per cycle from core logic on the same clock
`timescale 1ns/100ps
module multiply_divide_coprocessor (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // register access
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // status
  output logic BUSY,
  output logic RESULT_PENDING
);
  import muldiv_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0][7:0] md;   // operand/result bytes
    logic mdef;            // error flag
    logic mdov;            // overflow flag
    logic slr;             // shift direction
    logic [4:0] shift_cnt; // shift count field
    logic load_on;         // load sequence open
    logic seen23;          // byte2 or byte3 written
    logic last4;           // byte4 written after byte1
    logic busy;            // engine running
    logic pend;            // results not yet fully read
    logic pend_div;        // last read is byte5
    op_t op;               // running operation
    logic [7:0] rdata;     // read data
  } top_t;

  top_t s;
  top_t next_s;
  logic start;             // start pulse to engine
  logic abort;             // abort pulse to engine
  op_t sel_op;             // operation chosen by write order
  logic in_md;             // address hits an operand byte
  logic [2:0] idx;         // operand byte index
  logic wr_byte0;          // write to byte0
  logic eng_done;
  logic eng_ovf;
  logic [47:0] eng_res;
  logic [4:0] eng_cnt;

  assign in_md = (SFR_ADDR >= ADDR_BYTE0) && (SFR_ADDR <= ADDR_BYTE5);
  assign idx = 3'(SFR_ADDR - ADDR_BYTE0);
  assign wr_byte0 = SFR_WR && (SFR_ADDR == ADDR_BYTE0);

  // ---------------------------------------------------------------
  // sequencing and register file
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    start = 1'b0;
    abort = 1'b0;
    sel_op = OP_SHIFT;
    if (eng_done) begin
      next_s.md = eng_res;
      next_s.mdov = eng_ovf;
      if (s.op == OP_NORM) next_s.shift_cnt = eng_cnt;
      next_s.busy = 1'b0;
      next_s.pend = 1'b1;
      next_s.pend_div = (s.op == OP_DIV32) || (s.op == OP_DIV16);
    end
    if (SFR_WR) begin
      if (wr_byte0) begin
        // new start while busy or unread
        if (s.busy || s.pend) begin
          next_s.mdef = 1'b1;
        end else begin
          // flags clear at a byte0 write while idle and read; mdov also takes the engine's overflow when it finishes
          next_s.mdef = 1'b0;
          next_s.mdov = 1'b0;
        end
        abort = s.busy;
        next_s.busy = 1'b0;
        next_s.pend = 1'b0;
        next_s.md[0] = SFR_WDATA;
        next_s.load_on = 1'b1;
        next_s.seen23 = 1'b0;
        next_s.last4 = 1'b0;
      end else if (in_md && SFR_ADDR != ADDR_BYTE5 && !s.busy) begin
        next_s.md[idx] = SFR_WDATA;
        if (s.load_on) begin
          if (SFR_ADDR == ADDR_BYTE2 || SFR_ADDR == ADDR_BYTE3) next_s.seen23 = 1'b1;
          if (SFR_ADDR == ADDR_BYTE4) next_s.last4 = 1'b1;
          if (SFR_ADDR == ADDR_BYTE1) next_s.last4 = 1'b0;
        end
      end else if (SFR_ADDR == ADDR_BYTE5 && !s.busy) begin
        next_s.md[5] = SFR_WDATA;
        if (s.load_on) begin
          start = 1'b1;
          sel_op = s.seen23 ? OP_DIV32 : (s.last4 ? OP_DIV16 : OP_MUL);
        end
      end else if (SFR_ADDR == ADDR_CTRL && !s.busy) begin
        next_s.slr = SFR_WDATA[BIT_SLR];
        next_s.shift_cnt = SFR_WDATA[CNT_MSB:0];
        if (s.load_on) begin
          start = 1'b1;
          sel_op = (SFR_WDATA[CNT_MSB:0] == 5'h00) ? OP_NORM : OP_SHIFT;
        end
      end
    end
    if (start) begin
      next_s.busy = 1'b1;
      next_s.load_on = 1'b0;
      next_s.pend = 1'b0;
      next_s.op = sel_op;
    end
    // read mux; unmapped addresses read zero
    if (SFR_RD) begin
      if (in_md) next_s.rdata = s.md[idx];
      else if (SFR_ADDR == ADDR_CTRL) next_s.rdata = {s.mdef, s.mdov, s.slr, s.shift_cnt};
      else next_s.rdata = 8'h00;
      if (s.pend && SFR_ADDR == (s.pend_div ? ADDR_BYTE5 : ADDR_BYTE3)) next_s.pend = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // engine
  // ---------------------------------------------------------------
  muldiv_engine u_engine (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .start(start),
    .abort(abort),
    .op(sel_op),
    .opnd(next_s.md),
    .shift_cnt(next_s.shift_cnt),
    .slr(next_s.slr),
    .done(eng_done),
    .ovf(eng_ovf),
    .res(eng_res),
    .cnt(eng_cnt)
  );

  // state register; reset clears control/status
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '{md: {6{MD_RESET}}, mdef: CTRL_RESET[BIT_MDEF], mdov: CTRL_RESET[BIT_MDOV],
             slr: CTRL_RESET[BIT_SLR], shift_cnt: CTRL_RESET[CNT_MSB:0], load_on: 1'b0,
             seen23: 1'b0, last4: 1'b0, busy: 1'b0, pend: 1'b0, pend_div: 1'b0,
             op: OP_SHIFT, rdata: 8'h00};
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign SFR_RDATA = s.rdata;
  assign BUSY = s.busy;
  assign RESULT_PENDING = s.pend;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N || !CE);

  property p_err_set;
    wr_byte0 && (s.busy || s.pend) |=> s.mdef;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set on restart");
  property p_ovf;
    eng_done && eng_ovf && !wr_byte0 |=> s.mdov && !BUSY;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");
  property p_norm_sel;
    SFR_WR && SFR_ADDR == ADDR_CTRL && s.load_on && !s.busy && SFR_WDATA[4:0] == 5'h00
      |=> s.op == OP_NORM && BUSY;
  endproperty
  a_norm_sel: assert property (p_norm_sel) else $error("normalize not selected");
  property p_norm_cnt;
    eng_done && s.op == OP_NORM |=> s.shift_cnt == $past(eng_cnt);
  endproperty
  a_norm_cnt: assert property (p_norm_cnt) else $error("normalize count lost");
  property p_div32_sel;
    start && s.seen23 && SFR_ADDR == ADDR_BYTE5 |=> s.op == OP_DIV32;
  endproperty
  a_div32_sel: assert property (p_div32_sel) else $error("32/16 division not selected");
  property p_shift_time;
    start && sel_op == OP_SHIFT && next_s.shift_cnt == 5'h01 ##1 (!wr_byte0)[*2]
      |-> ##1 BUSY ##1 !BUSY;
  endproperty
  a_shift_time: assert property (p_shift_time) else $error("shift by one not 3 cycles");
  property p_div16_time;
    start && sel_op == OP_DIV16 ##1 (!wr_byte0)[*8] |-> ##1 BUSY ##1 !BUSY;
  endproperty
  a_div16_time: assert property (p_div16_time) else $error("16/16 division not 9 cycles");
  property p_start_busy;
    start |=> BUSY && !RESULT_PENDING;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");
  property p_last_read;
    SFR_RD && s.pend && !eng_done && SFR_ADDR == (s.pend_div ? ADDR_BYTE5 : ADDR_BYTE3)
      |=> !RESULT_PENDING;
  endproperty
  a_last_read: assert property (p_last_read) else $error("last read did not end it");
  property p_flag_hold;
    !wr_byte0 && !eng_done |=> $stable(s.mdov) && $stable(s.mdef);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause");

  c_div32: cover property (start && sel_op == OP_DIV32 ##[1:20] eng_done);
  c_mul_ovf: cover property (eng_done && eng_ovf && s.op == OP_MUL);
  c_norm: cover property (eng_done && s.op == OP_NORM);
  c_restart: cover property (wr_byte0 && s.busy);
endmodule : multiply_divide_coprocessor

/* File: hw/mdu_pkg.sv */
// constants and types shared by the multiply/divide co-processor files
// assumes a single core clock and byte-wide special function register accesses
package muldiv_pkg;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_BYTE0 = 8'he9;
  localparam logic [7:0] ADDR_BYTE1 = 8'hea;
  localparam logic [7:0] ADDR_BYTE2 = 8'heb;
  localparam logic [7:0] ADDR_BYTE3 = 8'hec;
  localparam logic [7:0] ADDR_BYTE4 = 8'hed;
  localparam logic [7:0] ADDR_BYTE5 = 8'hee;
  localparam logic [7:0] ADDR_CTRL = 8'hef;
  // ---------------------------------------------------------------
  // control/status field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_MDEF = 7;
  localparam int BIT_MDOV = 6;
  localparam int BIT_SLR = 5;
  localparam int CNT_MSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MD_RESET = 8'h00;
  // ---------------------------------------------------------------
  // execution cycle counts and bit step counts
  // ---------------------------------------------------------------
  localparam logic [4:0] CYC_DIV32 = 5'h11;
  localparam logic [4:0] CYC_DIV16 = 5'h09;
  localparam logic [4:0] CYC_MUL = 5'h0b;
  localparam logic [4:0] CYC_SHIFT_BASE = 5'h02;
  localparam logic [4:0] CYC_NORM_BASE = 5'h03;
  localparam logic [5:0] STEPS_DIV32 = 6'h20;
  localparam logic [5:0] STEPS_16 = 6'h10;
  // ---------------------------------------------------------------
  // operations and engine states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_DIV32 = 5'b00001,
    OP_DIV16 = 5'b00010,
    OP_MUL = 5'b00100,
    OP_SHIFT = 5'b01000,
    OP_NORM = 5'b10000
  } op_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN = 2'b10
  } eng_st_t;
endpackage : muldiv_pkg

/* File: hw/mdu_engine.sv */
// iterative arithmetic engine, two bit steps per clock
// assumes start only while idle; operands are stable in the start cycle
`timescale 1ns/100ps
module muldiv_engine (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic abort,
  input wire muldiv_pkg::op_t op,
  input wire logic [47:0] opnd,
  input wire logic [4:0] shift_cnt,
  input wire logic slr,
  // results
  output logic done,
  output logic ovf,
  output logic [47:0] res,
  output logic [4:0] cnt
);
  import muldiv_pkg::*;

  // whole engine state
  typedef struct packed {
    eng_st_t st;
    op_t op;
    logic slr;
    logic [15:0] dvs;
    logic [31:0] acc;
    logic [16:0] hi;
    logic [5:0] steps;
    logic [4:0] lat;
    logic [4:0] cnt;
  } eng_t;

  eng_t s;
  eng_t next_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // leading zeros, capped at 31 for a zero operand
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic hit;
    n = 5'h00;
    hit = 1'b0;
    for (int i = 31; i > 0; i--) begin
      if (!hit) begin
        if (v[i]) hit = 1'b1;
        else n = n + 5'h01;
      end
    end
    return n;
  endfunction : lead_zeros

  // half of a count, rounded up
  function automatic logic [4:0] half_up(input logic [4:0] v);
    logic [5:0] t;
    t = {1'b0, v} + 6'h01;
    return t[5:1];
  endfunction : half_up

  // one bit step of the running operation
  function automatic eng_t step(input eng_t w);
    eng_t r;
    logic [16:0] t;
    logic [16:0] sum;
    r = w;
    t = 17'h00000;
    sum = 17'h00000;
    if (w.steps != 6'h00) begin
      r.steps = w.steps - 6'h01;
      case (w.op)
        // restoring division step
        OP_DIV32, OP_DIV16: begin
          t = {w.hi[15:0], w.acc[31]};
          if (t >= {1'b0, w.dvs}) begin
            r.hi = t - {1'b0, w.dvs};
            r.acc = {w.acc[30:0], 1'b1};
          end else begin
            r.hi = t;
            r.acc = {w.acc[30:0], 1'b0};
          end
        end
        // shift-add multiplication step
        OP_MUL: begin
          sum = {1'b0, w.hi[15:0]} + (w.acc[0] ? {1'b0, w.dvs} : 17'h00000);
          r.hi = {1'b0, sum[16:1]};
          r.acc = {16'h0000, sum[0], w.acc[15:1]};
        end
        OP_SHIFT, OP_NORM: begin
          r.acc = w.slr ? {1'b0, w.acc[31:1]} : {w.acc[30:0], 1'b0};
        end
        default: r.steps = 6'h00;
      endcase
    end
    return r;
  endfunction : step

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    case (s.st)
      // load operands and cycle budget
      ENG_IDLE: begin
        if (start) begin
          next_s.st = ENG_RUN;
          next_s.op = op;
          next_s.slr = slr && (op == OP_SHIFT);
          next_s.hi = 17'h00000;
          next_s.cnt = 5'h00;
          next_s.dvs = opnd[47:32];
          next_s.acc = opnd[31:0];
          case (op)
            OP_DIV32: begin
              next_s.steps = STEPS_DIV32;
              next_s.lat = CYC_DIV32 - 5'h01;
            end
            OP_DIV16: begin
              next_s.acc = {opnd[15:0], 16'h0000};
              next_s.steps = STEPS_16;
              next_s.lat = CYC_DIV16 - 5'h01;
            end
            OP_MUL: begin
              next_s.acc = {16'h0000, opnd[15:0]};
              next_s.steps = STEPS_16;
              next_s.lat = CYC_MUL - 5'h01;
            end
            OP_SHIFT: begin
              next_s.steps = {1'b0, shift_cnt};
              next_s.lat = CYC_SHIFT_BASE + half_up(shift_cnt) - 5'h01;
            end
            default: begin
              next_s.cnt = lead_zeros(opnd[31:0]);
              next_s.steps = {1'b0, next_s.cnt};
              next_s.lat = CYC_NORM_BASE + half_up(next_s.cnt) - 5'h01;
            end
          endcase
        end
      end
      // two steps per cycle until the budget runs out
      ENG_RUN: begin
        if (abort || s.lat == 5'h00) begin
          next_s.st = ENG_IDLE;
        end else begin
          next_s = step(step(s));
          next_s.lat = s.lat - 5'h01;
        end
      end
      default: next_s.st = ENG_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // result mapping
  // ---------------------------------------------------------------
  assign done = (s.st == ENG_RUN) && (s.lat == 5'h00);
  assign cnt = s.cnt;

  // overflow on zero divisor or wide product
  always_comb begin
    res = {s.hi[15:0], s.acc};
    ovf = 1'b0;
    case (s.op)
      OP_DIV32: ovf = (s.dvs == 16'h0000);
      OP_DIV16: begin
        res = {s.hi[15:0], 16'h0000, s.acc[15:0]};
        ovf = (s.dvs == 16'h0000);
      end
      OP_MUL: begin
        res = {s.dvs, s.hi[15:0], s.acc[15:0]};
        ovf = (s.hi[15:0] != 16'h0000);
      end
      default: res = {s.dvs, s.acc};
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{st: ENG_IDLE, op: OP_SHIFT, slr: 1'b0, dvs: 16'h0000, acc: 32'h00000000,
             hi: 17'h00000, steps: 6'h00, lat: 5'h00, cnt: 5'h00};
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule : muldiv_engine

/* File: testbench/sfr_core_model.sv */
// model of the core side of the special function register bus
// assumes the co-processor takes strobes on the rising clock edge
`timescale 1ns/100ps
module sfr_core_model (
  // clock and read data
  input wire logic clk,
  input wire logic [7:0] rdata,
  // bus requests
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  // idle cycles before each access, to act as a slow core
  int gap = 0;

  // bus idle from time zero
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one write strobe; released lines show the inverse, never a stale value
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr_reg

  // one read strobe; data is taken once the registered answer has settled
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : sfr_core_model

/* File: testbench/test_multiply_divide_coprocessor.sv */
// self-checking bench of the multiply/divide co-processor
// assumes the core bus model in sfr_core_model and the shared package constants
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module test_multiply_divide_coprocessor;
  import muldiv_pkg::*;
  // clock, reset, enable
  logic CLK;
  logic RESET_N;
  logic CE;
  // bus and status nets
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic BUSY;
  logic RESULT_PENDING;
  // counters of the run
  int errors = 0;
  int n_compared = 0;

  multiply_divide_coprocessor u_dut (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
    .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata),
    .SFR_RDATA(sfr_rdata), .BUSY(BUSY), .RESULT_PENDING(RESULT_PENDING));
  sfr_core_model u_core (.clk(CLK), .rdata(sfr_rdata), .addr(sfr_addr), .wr(sfr_wr),
    .rd(sfr_rd), .wdata(sfr_wdata));

  // 200 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // prints the counts and the verdict, then ends the run
  task automatic tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // counts busy cycles after the starting write, bounded
  task automatic wait_done(input int n);
    int c;
    c = 0;
    #1;
    while (BUSY === 1'b1 && c < 64) begin
      c++;
      @(posedge CLK);
      #1;
    end
    if (c >= 64) begin
      errors++;
      tally_and_finish();
    end
    `CHK(c, n)
  endtask : wait_done

  // reads result bytes in order; the last read closes the calculation
  task automatic chk_res(input logic [47:0] exp, input int nb);
    logic [7:0] d;
    `CHK(RESULT_PENDING, 1'b1)
    for (int i = 0; i < nb; i++) begin
      u_core.rd_reg(ADDR_BYTE0 + 8'(i), d);
      `CHK(d, exp[8*i +: 8])
    end
    `CHK(RESULT_PENDING, 1'b0)
  endtask : chk_res

  task automatic load32(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      u_core.wr_reg(ADDR_BYTE0 + 8'(i), v[8*i +: 8]);
    end
  endtask : load32

  task automatic mul_load(input logic [15:0] a, input logic [15:0] b);
    u_core.wr_reg(ADDR_BYTE0, a[7:0]);
    u_core.wr_reg(ADDR_BYTE4, b[7:0]);
    u_core.wr_reg(ADDR_BYTE1, a[15:8]);
    u_core.wr_reg(ADDR_BYTE5, b[15:8]);
  endtask : mul_load

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // control clear after reset, unmapped read gives zero
  task automatic t_reset;
    logic [7:0] d;
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d, 8'h00)
    u_core.rd_reg(8'h00, d);
    `CHK(d, 8'h00)
    `CHK(BUSY, 1'b0)
  endtask : t_reset

  // byte1 written last before byte5: multiplication
  task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    logic [7:0] d;
    p = 32'(a) * 32'(b);
    mul_load(a, b);
    wait_done(11);
    chk_res({b, p}, 4);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[6], p > 32'h0000ffff)
  endtask : t_mul

  // byte2/3 written: 32/16 division
  task automatic t_div32(input logic [31:0] dvd, input logic [15:0] dvs);
    logic [7:0] d;
    load32(dvd);
    u_core.wr_reg(ADDR_BYTE4, dvs[7:0]);
    u_core.wr_reg(ADDR_BYTE5, dvs[15:8]);
    wait_done(17);
    chk_res({16'(dvd % 32'(dvs)), dvd / 32'(dvs)}, 6);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[7:6], 2'b00)
  endtask : t_div32

  // byte4 written after byte1: 16/16 division, zero divisor overflows
  task automatic t_div16(input logic [15:0] dvd, input logic [15:0] dvs);
    logic [47:0] e;
    logic [7:0] d;
    e = (dvs == 16'h0000) ? {dvd, 16'h0000, 16'hffff} : {dvd % dvs, 16'h0000, dvd / dvs};
    u_core.wr_reg(ADDR_BYTE0, dvd[7:0]);
    u_core.wr_reg(ADDR_BYTE1, dvd[15:8]);
    u_core.wr_reg(ADDR_BYTE4, dvs[7:0]);
    u_core.wr_reg(ADDR_BYTE5, dvs[15:8]);
    wait_done(9);
    chk_res(e, 6);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[6], dvs == 16'h0000)
  endtask : t_div16

  // shifts both ways, counts from 1 to 31
  task automatic t_shift;
    logic [5:0] tbl [4] = '{6'h01, 6'h3f, 6'h24, 6'h0c};
    logic [31:0] v;
    logic [7:0] d;
    int s;
    v = 32'h89abcdef;
    for (int i = 0; i < 4; i++) begin
      s = int'(tbl[i][4:0]);
      load32(v);
      u_core.wr_reg(ADDR_CTRL, {2'b00, tbl[i]});
      wait_done((s + 1) / 2 + 2);
      chk_res({16'h0000, tbl[i][5] ? v >> s : v << s}, 4);
      u_core.rd_reg(ADDR_CTRL, d);
      `CHK(d, {2'b00, tbl[i]})
    end
  endtask : t_shift

  // zero count normalizes and reports the shifts done
  task automatic t_norm(input logic [31:0] v);
    logic [7:0] d;
    logic [31:0] e;
    int n;
    e = v;
    n = 0;
    while (e[31] !== 1'b1 && n < 31) begin
      e = e << 1;
      n++;
    end
    load32(v);
    u_core.wr_reg(ADDR_CTRL, 8'h00);
    wait_done((n + 1) / 2 + 3);
    chk_res({16'h0000, e}, 4);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d, 8'(n))
  endtask : t_norm

  // restart while running and while results unread sets the error flag
  task automatic t_restart;
    logic [7:0] d;
    mul_load(16'h00ff, 16'h0002);
    u_core.wr_reg(ADDR_BYTE0, 8'h11);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[7], 1'b1)
    repeat (20) @(posedge CLK);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[7], 1'b1)
    t_mul(16'h0003, 16'h0005);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[7:6], 2'b00)
    mul_load(16'h0101, 16'h0202);
    wait_done(11);
    u_core.wr_reg(ADDR_BYTE0, 8'h00);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d[7], 1'b1)
  endtask : t_restart

  // clock enable low for three edges stretches a multiplication by three cycles
  task automatic t_freeze;
    mul_load(16'h0007, 16'h0009);
    CE <= 1'b0;
    repeat (3) @(posedge CLK);
    CE <= 1'b1;
    wait_done(11);
    chk_res({16'h0009, 32'h0000003f}, 4);
  endtask : t_freeze

  // reset in mid-run stops the engine and clears control and operand bytes
  task automatic t_midreset;
    logic [7:0] d;
    u_core.wr_reg(ADDR_CTRL, 8'h25);
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d, 8'h25)
    mul_load(16'h00ff, 16'h0002);
    RESET_N <= 1'b0;
    @(posedge CLK);
    RESET_N <= 1'b1;
    `CHK(BUSY, 1'b0)
    `CHK(RESULT_PENDING, 1'b0)
    u_core.rd_reg(ADDR_CTRL, d);
    `CHK(d, 8'h00)
    u_core.rd_reg(ADDR_BYTE0, d);
    `CHK(d, 8'h00)
  endtask : t_midreset

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    RESET_N = 1'b0;
    CE = 1'b1;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_mul(16'h1234, 16'h5678);
    t_div32(32'h89abcdef, 16'h1234);
    u_core.gap = 2;
    t_div32(32'hffffffff, 16'h0001);
    u_core.gap = 0;
    t_div16(16'hbeef, 16'h0123);
    t_div16(16'hbeef, 16'h0000);
    t_shift();
    t_norm(32'h00001234);
    t_freeze();
    t_midreset();
    t_restart();
    tally_and_finish();
  end
endmodule : test_multiply_divide_coprocessor
